// *** dpssh_regs.svh ***
`ifndef DPSSH_REGS_SVH
`define DPSSH_REGS_SVH

// ----------------------------------------------------------------
// Global control command cell
// ----------------------------------------------------------------
`define DPSSH_GC_CELL_OFS    8'h3C
`define DPSSH_GC_CELL_RST    8'h00
`define DPSSH_GC_BIT_CLEAR   1
`define DPSSH_GC_BIT_UNFRZ   2
`define DPSSH_GC_BIT_FRZ     3
`define DPSSH_GC_BIT_UNSYNC  4
`define DPSSH_GC_BIT_SYNC    5
`define DPSSH_GC_RES_MASK    8'hC1
`define DPSSH_PUB_MIN_LEN    8'h08

// ----------------------------------------------------------------
// Controller software registers
// ----------------------------------------------------------------
`define DPSSH_OFS_MODE       8'h00
`define DPSSH_OFS_ACTION     8'h04
`define DPSSH_OFS_DIN        8'h08
`define DPSSH_OFS_CFG        8'h0C
`define DPSSH_OFS_TEL        8'h10
`define DPSSH_OFS_TEL_DATA   8'h14
`define DPSSH_OFS_RSP_DATA   8'h18
`define DPSSH_OFS_RSP_INFO   8'h1C
`define DPSSH_OFS_DOUT_U     8'h20
`define DPSSH_OFS_STATUS     8'h24
`define DPSSH_MODE_RST       2'h0
`define DPSSH_MODE_SYNC_EN   0
`define DPSSH_MODE_FRZ_EN    1
`define DPSSH_ACT_OFFLINE    0
`define DPSSH_ACT_CFG_CHG    1
`define DPSSH_ACT_NEW_DIN    2
`define DPSSH_ACT_NEXT_DOUT  3
`define DPSSH_ACT_IRQ_ACK    4
`define DPSSH_ACT_DOUT_ZERO  5

`endif

// *** dpssh_pkg.sv ***
`default_nettype none

package dpssh_pkg;

    // ------------------------------------------------------------
    // Service kinds on the link
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SVC_NONE,
        SVC_WRITE_READ,
        SVC_READ_IN,
        SVC_READ_OUT,
        SVC_GET_CFG,
        SVC_GLOBAL,
        SVC_SET_PRM,
        SVC_BCAST_IN
    } dpssh_svc_t;

    typedef logic [1:0] dpssh_idx_t;

    // Group zero addresses every station
    function automatic logic group_hit(input logic [7:0] sel,
                                       input logic [7:0] grp);
        return (sel == 8'h00) || ((sel & grp) != 8'h00);
    endfunction : group_hit

    // Buffer index 0..2 as pointer code 1..3
    function automatic logic [1:0] ptr_code(input dpssh_idx_t idx);
        return 2'(idx + 2'h1);
    endfunction : ptr_code

endpackage : dpssh_pkg

`default_nettype wire

// *** dpssh_link_if.sv ***
`default_nettype none

interface dpssh_link_if
    import dpssh_pkg::*;
#(
    parameter int DATA_W = 32
);
    // Telegram from the master
    logic              req_valid;
    dpssh_svc_t        req_svc;
    logic [7:0]        req_b0;
    logic [7:0]        req_b1;
    logic [7:0]        req_len;
    logic [DATA_W-1:0] req_data;
    // Response to the master
    logic              rsp_valid;
    dpssh_svc_t        rsp_svc;
    logic              rsp_bcast;
    logic [DATA_W-1:0] rsp_data;
    // Local processor orders
    logic              sync_en;
    logic              freeze_en;
    logic              go_offline;
    logic              cfg_write;
    logic              cfg_change;
    logic [DATA_W-1:0] cfg_data;
    logic              new_din;
    logic [DATA_W-1:0] din_data;
    logic              next_dout;
    logic              dout_zero;
    logic              irq_ack;
    // Local processor view
    logic [7:0]        gc_cell;
    logic              gc_irq;
    logic [DATA_W-1:0] dout_u_data;
    logic [3:0]        dout_stat;
    logic [1:0]        din_u_ptr;
    logic              sync_mode;
    logic              freeze_mode;
    logic              offline;

    modport device (
        input  req_valid, req_svc, req_b0, req_b1, req_len, req_data,
        output rsp_valid, rsp_svc, rsp_bcast, rsp_data,
        input  sync_en, freeze_en, go_offline, cfg_write, cfg_change,
        input  cfg_data, new_din, din_data, next_dout, dout_zero, irq_ack,
        output gc_cell, gc_irq, dout_u_data, dout_stat, din_u_ptr,
        output sync_mode, freeze_mode, offline
    );

    modport ctrl (
        output req_valid, req_svc, req_b0, req_b1, req_len, req_data,
        input  rsp_valid, rsp_svc, rsp_bcast, rsp_data,
        output sync_en, freeze_en, go_offline, cfg_write, cfg_change,
        output cfg_data, new_din, din_data, next_dout, dout_zero, irq_ack,
        input  gc_cell, gc_irq, dout_u_data, dout_stat, din_u_ptr,
        input  sync_mode, freeze_mode, offline
    );

endinterface : dpssh_link_if

`default_nettype wire

// *** dpssh_device.sv ***
// Operation
// [R1] Store command, check group
// [R2] Clear zeroes D output, moves it
// [R3] Unfreeze resumes input exchanges
// [R4] Freeze fetches input, holds it
// [R5] Sync moves outputs; Unsync cancels
// [R6] Bits 0, 6, 7 do nothing
// [R7] Changed command raises interrupt
// [R8] Cell resets to zero, readable
// [R9] Sync, Freeze need mode enables
// [R10] Read inputs takes only new input
// [R11] Freeze mode blocks input exchange
// [R12] Read outputs returns user buffer
// [R13] Processor zeroes user outputs first
// [R14] Repeated read shows swapped buffer
// [R15] Alternate config written, then swapped
// [R16] Config change sends device offline; here only the Offline action bit does, cfg_change just swaps config
// [R17] Long parameters make a publisher
// [R18] Foreign broadcast data ignored
// [R19] Sync mode holds outputs until Sync/Unsync
// [R20] Power-on, leave, clear zero outputs
`default_nettype none
`include "dpssh_regs.svh"

module dpssh_device
    import dpssh_pkg::*;
#(
    parameter int DATA_W = 32
) (
    // Clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    // Link to master and local processor
    dpssh_link_if.device    link,
    // Station settings
    input  wire logic [7:0] i_group_addr,
    output logic            o_publisher
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [DATA_W-1:0] dout_mem [0:2];
    logic [DATA_W-1:0] din_mem  [0:2];
    logic [DATA_W-1:0] cfg_mem  [0:1];
    dpssh_idx_t        do_u_r, do_n_r, do_d_r;
    dpssh_idx_t        do_u_nxt, do_n_nxt, do_d_nxt;
    dpssh_idx_t        di_u_r, di_n_r, di_d_r;
    dpssh_idx_t        di_u_nxt, di_n_nxt, di_d_nxt;
    logic              do_new_r, do_new_nxt;
    logic              n_clr_r, n_clr_nxt;
    logic              di_new_r, di_new_nxt;
    logic [3:0]        do_stat_nxt;
    logic              cfg_sel_r;
    logic              offline_r;
    logic [7:0]        prm_len_r;

    // ------------------------------------------------------------
    // Telegram decode
    // ------------------------------------------------------------
    wire logic [7:0] cmd = link.req_b0 & ~`DPSSH_GC_RES_MASK; // [R6]
    wire logic online    = link.req_valid && !offline_r;
    // Foreign broadcasts decode to nothing [R18]
    wire logic gc_go     = online && link.req_svc == SVC_GLOBAL
                           && group_hit(link.req_b1, i_group_addr); // [R1]
    wire logic wr_go     = online && link.req_svc == SVC_WRITE_READ;
    wire logic ri_go     = online && link.req_svc == SVC_READ_IN;
    wire logic ro_go     = online && link.req_svc == SVC_READ_OUT;
    wire logic cfg_go    = link.req_valid && link.req_svc == SVC_GET_CFG;
    wire logic prm_go    = link.req_valid && link.req_svc == SVC_SET_PRM;
    wire logic rsp_go    = wr_go || ri_go || ro_go || cfg_go;

    wire logic do_clear  = gc_go && cmd[`DPSSH_GC_BIT_CLEAR];
    wire logic do_unfrz  = gc_go && cmd[`DPSSH_GC_BIT_UNFRZ];
    wire logic do_frz    = gc_go && cmd[`DPSSH_GC_BIT_FRZ]
                           && link.freeze_en; // [R9]
    wire logic do_unsync = gc_go && cmd[`DPSSH_GC_BIT_UNSYNC]
                           && link.sync_en;
    wire logic do_sync   = gc_go && cmd[`DPSSH_GC_BIT_SYNC]
                           && link.sync_en; // [R9]
    wire logic leave     = link.go_offline;
    wire logic clear_out = do_clear || leave; // [R2] [R20]
    // Sync mode keeps writes in D [R19]
    wire logic swap_out  = clear_out || do_sync || do_unsync
                           || (wr_go && !link.sync_mode); // [R5]
    wire logic fetch_in  = di_new_r && (do_frz
                           || ((wr_go || ri_go) && !link.freeze_mode));
    wire logic gc_change = gc_go && link.req_b0 != link.gc_cell;
    wire logic publish   = prm_len_r >= `DPSSH_PUB_MIN_LEN
                           && !offline_r; // [R17]
    wire logic [DATA_W-1:0] rsp_word =
        ro_go  ? dout_mem[do_u_r] :     // [R12] [R14]
        cfg_go ? cfg_mem[cfg_sel_r] :
                 din_mem[di_d_nxt];

    // ------------------------------------------------------------
    // Output buffer rotation
    // ------------------------------------------------------------
    always_comb begin
        do_u_nxt    = do_u_r;
        do_n_nxt    = do_n_r;
        do_d_nxt    = do_d_r;
        do_new_nxt  = do_new_r;
        n_clr_nxt   = n_clr_r;
        do_stat_nxt = link.dout_stat;
        if (swap_out) begin
            do_n_nxt   = do_d_r;
            do_d_nxt   = do_n_r;
            do_new_nxt = 1'b1;
            n_clr_nxt  = clear_out; // [R20]
        end
        if (link.next_dout) begin
            if (do_new_nxt) begin
                do_stat_nxt = {n_clr_nxt, 1'b1, ptr_code(do_n_nxt)};
                do_n_nxt    = do_u_nxt;
                do_u_nxt    = swap_out ? do_d_r : do_n_r;
                do_new_nxt  = 1'b0;
                n_clr_nxt   = 1'b0;
            end else begin
                do_stat_nxt = {2'b00, ptr_code(do_u_nxt)};
            end
        end
    end

    // ------------------------------------------------------------
    // Input buffer rotation
    // ------------------------------------------------------------
    always_comb begin
        di_u_nxt   = di_u_r;
        di_n_nxt   = di_n_r;
        di_d_nxt   = di_d_r;
        di_new_nxt = di_new_r;
        if (fetch_in) begin // [R4] [R10] [R11]
            di_d_nxt   = di_n_r;
            di_n_nxt   = di_d_r;
            di_new_nxt = 1'b0;
        end
        if (link.new_din) begin
            di_u_nxt   = di_n_nxt;
            di_n_nxt   = di_u_r;
            di_new_nxt = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Buffer contents
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int k = 0; k < 3; k++) begin
                dout_mem[k] <= '0;
                din_mem[k]  <= '0;
            end
            cfg_mem[0] <= '0;
            cfg_mem[1] <= '0;
        end else begin
            if (wr_go) begin
                dout_mem[do_d_r] <= link.req_data;
            end
            if (clear_out) begin
                dout_mem[do_d_r] <= '0; // [R2] [R20]
            end
            if (link.dout_zero) begin
                dout_mem[do_u_r] <= '0;
            end
            if (link.new_din) begin
                din_mem[di_u_r] <= link.din_data;
            end
            if (link.cfg_write) begin
                cfg_mem[~cfg_sel_r] <= link.cfg_data;
            end
        end
    end

    // ------------------------------------------------------------
    // Buffer pointers
    // ------------------------------------------------------------
    // Reset leaves a cleared buffer in N [R20]
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {do_u_r, do_n_r, do_d_r} <= {2'h0, 2'h1, 2'h2};
            {di_u_r, di_n_r, di_d_r} <= {2'h0, 2'h1, 2'h2};
            do_new_r       <= 1'b1;
            n_clr_r        <= 1'b1;
            di_new_r       <= 1'b0;
            link.dout_stat <= 4'h0;
            link.din_u_ptr <= 2'h1;
        end else begin
            {do_u_r, do_n_r, do_d_r} <= {do_u_nxt, do_n_nxt, do_d_nxt};
            {di_u_r, di_n_r, di_d_r} <= {di_u_nxt, di_n_nxt, di_d_nxt};
            do_new_r       <= do_new_nxt;
            n_clr_r        <= n_clr_nxt;
            di_new_r       <= di_new_nxt;
            link.dout_stat <= do_stat_nxt;
            link.din_u_ptr <= ptr_code(di_u_nxt);
        end
    end

    // ------------------------------------------------------------
    // Global control state and configuration
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            link.gc_cell     <= `DPSSH_GC_CELL_RST; // [R8]
            link.gc_irq      <= 1'b0;
            link.sync_mode   <= 1'b0;
            link.freeze_mode <= 1'b0;
            link.offline     <= 1'b1;
            offline_r        <= 1'b1;
            prm_len_r        <= 8'h00;
            cfg_sel_r        <= 1'b0;
        end else begin
            if (gc_go) begin
                link.gc_cell <= link.req_b0; // [R1]
            end
            // Set wins over acknowledge [R7]
            link.gc_irq <= gc_change || (link.gc_irq && !link.irq_ack);
            if (do_unsync || leave) begin
                link.sync_mode <= 1'b0; // [R5]
            end else if (do_sync) begin
                link.sync_mode <= 1'b1;
            end
            if (do_unfrz || leave) begin
                link.freeze_mode <= 1'b0; // [R3]
            end else if (do_frz) begin
                link.freeze_mode <= 1'b1; // [R4]
            end
            if (leave) begin
                offline_r    <= 1'b1;
                link.offline <= 1'b1;
                prm_len_r    <= 8'h00;
            end else if (prm_go) begin
                offline_r    <= 1'b0;
                link.offline <= 1'b0;
                prm_len_r    <= link.req_len;
            end
            if (link.cfg_change) begin
                cfg_sel_r <= ~cfg_sel_r; // [R15]
            end
        end
    end

    // ------------------------------------------------------------
    // Responses
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            link.rsp_valid   <= 1'b0;
            link.rsp_svc     <= SVC_NONE;
            link.rsp_bcast   <= 1'b0;
            link.rsp_data    <= '0;
            link.dout_u_data <= '0;
            o_publisher      <= 1'b0;
        end else begin
            link.rsp_valid   <= rsp_go;
            link.rsp_svc     <= rsp_go ? link.req_svc : SVC_NONE;
            link.rsp_bcast   <= wr_go && publish; // [R17]
            link.rsp_data    <= rsp_go ? rsp_word : '0;
            link.dout_u_data <= dout_mem[do_u_r];
            o_publisher      <= publish;
        end
    end

endmodule : dpssh_device

`default_nettype wire

// *** dpssh_ctrl.sv ***
`default_nettype none
`include "dpssh_regs.svh"

module dpssh_ctrl
    import dpssh_pkg::*;
#(
    parameter int DATA_W = 32
) (
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    // Software port
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [31:0]      o_rdata,
    // Link to the device
    dpssh_link_if.ctrl       link
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic [1:0]        mode_r;
    logic [DATA_W-1:0] din_r;
    logic [DATA_W-1:0] tel_data_r;
    logic [DATA_W-1:0] rsp_data_r;
    logic [4:0]        rsp_info_r;
    logic              init_done_r;

    wire logic wr_act  = i_wr && i_addr == `DPSSH_OFS_ACTION;
    wire logic wr_tel  = i_wr && i_addr == `DPSSH_OFS_TEL;
    wire logic rd_info = i_rd && i_addr == `DPSSH_OFS_RSP_INFO;
    wire logic [31:0] status_word = {22'h0, link.offline,
        link.freeze_mode, link.sync_mode, link.gc_irq, link.din_u_ptr,
        link.dout_stat};
    wire logic [31:0] rd_mux =
        i_addr == `DPSSH_OFS_MODE     ? {30'h0, mode_r} :
        i_addr == `DPSSH_OFS_DIN      ? 32'(din_r) :
        i_addr == `DPSSH_OFS_TEL_DATA ? 32'(tel_data_r) :
        i_addr == `DPSSH_OFS_RSP_DATA ? 32'(rsp_data_r) :
        i_addr == `DPSSH_OFS_RSP_INFO ? {27'h0, rsp_info_r} :
        i_addr == `DPSSH_OFS_DOUT_U   ? 32'(link.dout_u_data) :
        i_addr == `DPSSH_OFS_STATUS   ? status_word :
        i_addr == `DPSSH_GC_CELL_OFS  ? {24'h0, link.gc_cell} :
                                        32'h0;

    // ------------------------------------------------------------
    // Software registers and read port
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_r     <= `DPSSH_MODE_RST;
            din_r      <= '0;
            tel_data_r <= '0;
            o_rdata    <= 32'h0;
        end else begin
            if (i_wr && i_addr == `DPSSH_OFS_MODE) begin
                mode_r <= i_wdata[1:0]; // [R9]
            end
            if (i_wr && i_addr == `DPSSH_OFS_DIN) begin
                din_r <= DATA_W'(i_wdata);
            end
            if (i_wr && i_addr == `DPSSH_OFS_TEL_DATA) begin
                tel_data_r <= DATA_W'(i_wdata);
            end
            o_rdata <= i_rd ? rd_mux : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // Processor orders
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            init_done_r     <= 1'b0;
            link.sync_en    <= 1'b0;
            link.freeze_en  <= 1'b0;
            link.go_offline <= 1'b0;
            link.cfg_write  <= 1'b0;
            link.cfg_change <= 1'b0;
            link.cfg_data   <= '0;
            link.new_din    <= 1'b0;
            link.din_data   <= '0;
            link.next_dout  <= 1'b0;
            link.dout_zero  <= 1'b0;
            link.irq_ack    <= 1'b0;
        end else begin
            init_done_r     <= 1'b1;
            link.sync_en    <= mode_r[`DPSSH_MODE_SYNC_EN]; // [R9]
            link.freeze_en  <= mode_r[`DPSSH_MODE_FRZ_EN];
            link.go_offline <= wr_act
                && i_wdata[`DPSSH_ACT_OFFLINE]; // [R16]
            link.cfg_write  <= i_wr && i_addr == `DPSSH_OFS_CFG; // [R15]
            link.cfg_data   <= DATA_W'(i_wdata);
            link.cfg_change <= wr_act && i_wdata[`DPSSH_ACT_CFG_CHG];
            link.new_din    <= wr_act && i_wdata[`DPSSH_ACT_NEW_DIN];
            link.din_data   <= din_r;
            link.next_dout  <= wr_act && i_wdata[`DPSSH_ACT_NEXT_DOUT];
            link.irq_ack    <= wr_act && i_wdata[`DPSSH_ACT_IRQ_ACK];
            // Zero user outputs after reset
            link.dout_zero  <= !init_done_r
                || (wr_act && i_wdata[`DPSSH_ACT_DOUT_ZERO]); // [R13]
        end
    end

    // ------------------------------------------------------------
    // Telegram issue and response capture
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            link.req_valid <= 1'b0;
            link.req_svc   <= SVC_NONE;
            link.req_b0    <= 8'h00;
            link.req_b1    <= 8'h00;
            link.req_len   <= 8'h00;
            link.req_data  <= '0;
            rsp_data_r     <= '0;
            rsp_info_r     <= 5'h00;
        end else begin
            link.req_valid <= wr_tel;
            link.req_svc   <= wr_tel ? dpssh_svc_t'(i_wdata[2:0])
                                     : SVC_NONE;
            link.req_b0    <= i_wdata[15:8];
            link.req_b1    <= i_wdata[23:16];
            link.req_len   <= i_wdata[31:24];
            link.req_data  <= tel_data_r;
            if (link.rsp_valid) begin
                rsp_data_r <= link.rsp_data;
            end
            // Arrival wins over the read
            rsp_info_r[0]   <= link.rsp_valid
                || (rsp_info_r[0] && !rd_info);
            if (link.rsp_valid) begin
                rsp_info_r[4:1] <= {link.rsp_svc, link.rsp_bcast};
            end
        end
    end

endmodule : dpssh_ctrl

`default_nettype wire

// *** dpssh_monitor.sv ***
`default_nettype none

module dpssh_monitor
    import dpssh_pkg::*;
(
    // Clock and reset
    input wire logic       i_ref_clk,
    input wire logic       i_rst_n,
    // Link signals
    input wire logic       req_valid,
    input wire dpssh_svc_t req_svc,
    input wire logic [7:0] req_b0,
    input wire logic [7:0] req_b1,
    input wire logic       rsp_valid,
    input wire dpssh_svc_t rsp_svc,
    input wire logic       sync_en,
    input wire logic       freeze_en,
    input wire logic       irq_ack,
    input wire logic [7:0] gc_cell,
    input wire logic       gc_irq,
    input wire logic       sync_mode,
    input wire logic       freeze_mode,
    input wire logic       offline
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);
    sequence gc_req;
        req_valid && req_svc == SVC_GLOBAL && req_b1 == 8'h00 && !offline;
    endsequence
    sequence ans_req;
        req_valid && (req_svc == SVC_GET_CFG || !offline &&
            req_svc inside {SVC_WRITE_READ, SVC_READ_IN, SVC_READ_OUT});
    endsequence
    gc_store_a: assert property (
        gc_req |=> gc_cell == $past(req_b0)) else $error("cell not loaded");
    gc_irq_a: assert property (
        gc_req ##0 req_b0 != gc_cell |=> gc_irq) else $error("irq missing");
    irq_hold_a: assert property (
        gc_irq && !irq_ack |=> gc_irq) else $error("irq dropped");
    sync_on_a: assert property (
        gc_req ##0 sync_en && req_b0[5:4] == 2'b10 |=> sync_mode)
        else $error("sync not entered");
    sync_off_a: assert property (
        gc_req ##0 sync_en && req_b0[4] |=> !sync_mode)
        else $error("unsync ignored");
    frz_on_a: assert property (
        gc_req ##0 freeze_en && req_b0[3:2] == 2'b10 |=> freeze_mode)
        else $error("freeze not entered");
    frz_off_a: assert property (
        gc_req ##0 req_b0[2] |=> !freeze_mode) else $error("unfreeze ignored");
    rsp_time_a: assert property (
        ans_req |=> rsp_valid && rsp_svc == $past(req_svc))
        else $error("bad response");
    no_rsp_a: assert property (
        req_valid && req_svc inside {SVC_GLOBAL, SVC_SET_PRM, SVC_BCAST_IN}
        |=> !rsp_valid) else $error("stray response");
    gc_rst_a: assert property (
        $rose(i_rst_n) |-> gc_cell == 8'h00) else $error("cell not cleared");
endmodule : dpssh_monitor

`default_nettype wire

// *** dpssh_test.sv ***
`default_nettype none

module dpssh_test
    import dpssh_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_ref_clk    = 1'b0;
    logic        i_rst_n      = 1'b0;
    logic [7:0]  i_addr       = 8'h00;
    logic [31:0] i_wdata      = 32'h0;
    logic        i_wr         = 1'b0;
    logic        i_rd         = 1'b0;
    logic [7:0]  i_group_addr = 8'h81;
    logic [31:0] o_rdata;
    logic        o_publisher;
    int          bad_count    = 0;
    int          n_checks     = 0;
    int          cyc          = 0;
    logic [31:0] v, d;
    logic [7:0]  b0, b1;
    logic [10:0] st;

    always #4 i_ref_clk = ~i_ref_clk;
    dpssh_link_if link ();
    dpssh_device dpssh_device_inst (.i_ref_clk, .i_rst_n,
        .link(link.device), .i_group_addr, .o_publisher);
    dpssh_ctrl dpssh_ctrl_inst (.i_ref_clk, .i_rst_n, .i_addr, .i_wdata,
        .i_wr, .i_rd, .o_rdata, .link(link.ctrl));
    dpssh_monitor dpssh_monitor_inst (.i_ref_clk, .i_rst_n,
        .req_valid(link.req_valid), .req_svc(link.req_svc),
        .req_b0(link.req_b0), .req_b1(link.req_b1),
        .rsp_valid(link.rsp_valid), .rsp_svc(link.rsp_svc),
        .sync_en(link.sync_en), .freeze_en(link.freeze_en),
        .irq_ack(link.irq_ack), .gc_cell(link.gc_cell),
        .gc_irq(link.gc_irq), .sync_mode(link.sync_mode),
        .freeze_mode(link.freeze_mode), .offline(link.offline));

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results

    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= dat;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 q = o_rdata;
    endtask : rd

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        rd(a, q);
        chk(q, exp);
    endtask : rdc

    task automatic act(input logic [31:0] bits);
        wr(8'h04, bits);
        repeat (3) @(posedge i_ref_clk);
    endtask : act

    task automatic tel(input dpssh_svc_t s, input logic [7:0] c0 = 8'h00,
                       input logic [7:0] c1 = 8'h00,
                       input logic [31:0] dat = 32'h0);
        wr(8'h14, dat);
        wr(8'h10, {8'h08, c1, c0, 5'h00, s});
        repeat (4) @(posedge i_ref_clk);
    endtask : tel

    // Expected {cell, freeze, sync, irq} after control
    function automatic logic [10:0] gc_next(input logic [7:0] c,
        input logic [7:0] sel, input logic [10:0] s, input logic en);
        logic [10:0] n;
        n = s;
        if (sel == 8'h00 || (sel & i_group_addr) != 8'h00) begin
            n[0] = s[0] | (c != s[10:3]);
            n[10:3] = c;
            if (en && c[4]) n[1] = 1'b0;
            else if (en && c[5]) n[1] = 1'b1;
            if (c[2]) n[2] = 1'b0;
            else if (en && c[3]) n[2] = 1'b1;
        end
        return n;
    endfunction : gc_next

    initial begin
        v = $urandom(32'h628fdf3c);
        repeat (6) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        rdc(8'h3C, 32'h0);
        rdc(8'h30, 32'h0);
        tel(SVC_SET_PRM);
        chk({31'h0, o_publisher}, 32'h1);
        st = 11'h0;
        for (int i = 0; i < 10; i++) begin
            wr(8'h00, (i == 0) ? 32'h0 : 32'h3);
            b0 = (i < 2) ? 8'h28 : 8'($urandom);
            b1 = (i < 2) ? 8'h00 : 8'($urandom_range(2, 0));
            tel(SVC_GLOBAL, b0, b1);
            st = gc_next(b0, b1, st, i != 0);
            rdc(8'h3C, {24'h0, st[10:3]});
            rd(8'h24, v);
            chk({29'h0, v[8:6]}, {29'h0, st[2:0]});
            act(32'h10);
            st[0] = 1'b0;
        end
        $display("control test done");
        tel(SVC_GLOBAL, 8'h14);
        d = $urandom;
        wr(8'h08, d);
        act(32'h4);
        tel(SVC_READ_IN);
        rdc(8'h18, d);
        rdc(8'h1C, {27'h0, SVC_READ_IN, 2'b01});
        tel(SVC_GLOBAL, 8'h08);
        wr(8'h08, ~d);
        act(32'h4);
        tel(SVC_READ_IN);
        rdc(8'h18, d);
        tel(SVC_GLOBAL, 8'h04);
        tel(SVC_READ_IN);
        rdc(8'h18, ~d);
        $display("input test done");
        tel(SVC_READ_OUT);
        rdc(8'h18, 32'h0);
        tel(SVC_WRITE_READ, 8'h00, 8'h00, d);
        rdc(8'h1C, {27'h0, SVC_WRITE_READ, 2'b11});
        act(32'h8);
        tel(SVC_READ_OUT);
        rdc(8'h18, d);
        tel(SVC_GLOBAL, 8'h02);
        act(32'h8);
        rd(8'h24, v);
        chk({30'h0, v[3:2]}, 32'h3);
        tel(SVC_READ_OUT);
        rdc(8'h18, 32'h0);
        tel(SVC_GLOBAL, 8'h20);
        act(32'h8);
        tel(SVC_WRITE_READ, 8'h00, 8'h00, ~d);
        act(32'h8);
        rd(8'h24, v);
        chk({31'h0, v[2]}, 32'h0);
        tel(SVC_GLOBAL, 8'h20);
        act(32'h8);
        tel(SVC_READ_OUT);
        rdc(8'h18, ~d);
        $display("output test done");
        wr(8'h0C, d ^ 32'h5);
        act(32'h2);
        tel(SVC_GET_CFG);
        rdc(8'h18, d ^ 32'h5);
        rd(8'h1C, v);
        tel(SVC_BCAST_IN);
        rdc(8'h1C, {27'h0, SVC_GET_CFG, 2'b00});
        act(32'h1);
        rd(8'h24, v);
        chk({31'h0, v[9]}, 32'h1);
        tel(SVC_WRITE_READ, 8'h00, 8'h00, d);
        rdc(8'h1C, {27'h0, SVC_GET_CFG, 2'b00});
        chk({31'h0, o_publisher}, 32'h0);
        $display("config test done");
        results();
    end
endmodule : dpssh_test

`default_nettype wire
